// ==== pkg/fdc_host_consts.vh ====
// Constants for the floppy host status and reset logic
`ifndef FDC_HOST_CONSTS_VH
`define FDC_HOST_CONSTS_VH
`define OFS_DOR 8'h00
`define OFS_DSR 8'h04
`define OFS_MSR 8'h08
`define OFS_DATA 8'h0C
`define OFS_DIR 8'h10
`define OFS_CCR 8'h14
`define OFS_CFG 8'h18
`define OFS_STAT 8'h1C
`define DOR_RST_BIT 0
`define DOR_GATE_BIT 3
`define DSR_RST_BIT 7
`define DSR_PD_BIT 6
`define CCR_MASK_BIT 4
`define CCR_NOPRE_BIT 2
`define RATE_RESET 2'h2
`define RATE_1M 2'h3
`define RATE_500K 2'h0
`define RATE_300K 2'h1
`define RATE_250K 2'h2
`define KBPS_1M 11'd1000
`define KBPS_500K 11'd500
`define KBPS_300K 11'd300
`define KBPS_250K 11'd250
`define MODE_BASIC 2'h0
`define MODE_EXT 2'h1
`define MODE_ALT 2'h2
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// ==== logic/fdc_host_status_reset_logic.v ====
// Host port: registers, FIFO, resets and DMA request of a floppy controller
// Functional notes
// RL1: FIFO mode is off at command start; bytes go one at a time; the code keeps only host writes to one byte, reads drain up to 16.
// RL2: Entering execution flushes every byte held in the FIFO.
// RL3: Overrun or underrun ends the command and stops all transfer; the code still lets host data reads pop the FIFO.
// RL4: Underrun on a write pads the sector with zero bytes and CRC.
// RL5: Input register is read only; basic mode drives only bit 7.
// RL6: Disk-change bit is the inverse of the cable input.
// RL7: Auto powerdown forces disk-change inactive; other bits keep values.
// RL8: Bits 6 to 4 show idle, powerdown and mask when enabled.
// RL9: Active idle mask disables the idle output pin.
// RL10: Extended mode bit 3 reads 1, bits 2 and 1 give rate.
// RL11: Density bit low for 500K and 1M, high otherwise.
// RL12: Drive specification command may also load the rate code.
// RL13: Alternate mode: bit 7 inverted, bit 3 mirrors DMA gate.
// RL14: Alternate mode: bit 2 mirrors the no-precompensation bit.
// RL15: Config register is write only; rate in bits 1:0, reset 10.
// RL16: Config bit 4 is idle mask only with status enabled.
// RL17: No-precompensation bit has no effect; hardware reset clears it.
// RL18: Pin, output-register and rate-register resets all exit powerdown.
// RL19: Reset aborts and idles; release clears state and starts polling.
// RL20: Hardware reset clears registers and sets output-register reset.
// RL21: Software resets reset core; FIFO too only when lock is 0.
// RL22: Rate-register reset self clears; output-register reset persists.
// RL23: Host holds output-register reset at least 0.5 us at 250K.
// RL24: DMA request during transfers; acknowledge alone selects FIFO.
// RL25: Rate code 11=1M, 00=500K, 01=300K, 10=250K.
// RL26: Request bit lets host move a byte; direction 1 read.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "fdc_host_consts.vh"
module fdc_host_status_reset_logic (
    input wire clock_in,
    input wire srst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire media_change_pin_in,
    input wire dma_acknowledge_n_in,
    output wire dma_request_out,
    output wire idle_pin_out,
    input wire idle_in,
    input wire auto_pd_in,
    input wire cmd_start_in,
    input wire exec_start_in,
    input wire cmd_end_in,
    input wire transfer_direction_in,
    input wire lock_in,
    input wire fifo_cfg_en_in,
    input wire poll_disable_in,
    input wire spec_rate_we_in,
    input wire [1:0] spec_rate_in,
    input wire core_pop_in,
    output reg [7:0] core_data_out,
    input wire core_push_in,
    input wire [7:0] core_data_in,
    input wire sector_done_in,
    input wire is_disk_write_in,
    output wire fifo_empty_out,
    output wire fifo_full_out,
    output wire core_reset_out,
    output reg terminate_out,
    output reg zero_fill_out,
    output reg poll_enable_out,
    output wire powerdown_state_flag_out,
    output wire [1:0] rate_code_out,
    output reg [10:0] data_rate_kbps_out,
    output wire skip_write_shift_out
);
    // Two-stage synchronisers for pin inputs
    reg chg_s1_q;
    reg chg_s2_q;
    reg ack_s1_q;
    reg ack_s2_q;
    always @(posedge clock_in) begin
        chg_s1_q <= media_change_pin_in;
        chg_s2_q <= chg_s1_q;
        ack_s1_q <= dma_acknowledge_n_in;
        ack_s2_q <= ack_s1_q;
    end

    // Control registers
    reg dor_reset_q;
    reg dma_gate_n_q;
    reg dsr_reset_q;
    reg direct_pd_q;
    reg [1:0] rate_q;
    reg idle_pin_mask_q;
    reg skip_write_shift_q;
    reg [1:0] mode_q;
    reg pd_stat_en_q;
    reg srb_mask_q;
    reg dma_en_q;
    reg fifo_on_q;
    reg in_exec_q;
    reg stop_q;
    reg term_flag_q;
    reg was_reset_q;

    // FIFO storage
    reg [7:0] mem_q [0:`FIFO_DEPTH-1];
    reg [`FIFO_AW-1:0] wr_ptr_q;
    reg [`FIFO_AW-1:0] rd_ptr_q;
    reg [`FIFO_AW:0] count_q;

    wire sw_reset;
    wire any_reset;
    wire fifo_reset;
    wire dma_sel;
    wire bus_req;
    wire bus_wr;
    wire bus_rd;
    wire [7:0] adr_eff;
    wire host_push;
    wire host_pop;
    wire push;
    wire pop;
    wire overrun;
    wire underrun;
    wire host_transfer_request;
    wire media_changed_flag;
    wire high_density_indicator_n;
    wire idle_mask_eff;
    wire [2:0] pd_bits;
    reg [7:0] dir_val;
    reg [7:0] rd_val;

    // DIGITAL_OUTPUT_REGISTER reset persists and wins; DSR reset lasts one cycle [RL22]
    assign sw_reset = dor_reset_q | dsr_reset_q;
    assign any_reset = srst_in | sw_reset; // [RL18]
    assign core_reset_out = any_reset; // [RL19] [RL21]
    // FIFO survives a software reset when locked [RL21]
    assign fifo_reset = srst_in | (sw_reset & ~lock_in);

    // Acknowledge alone selects the FIFO, address ignored [RL24]
    assign dma_sel = ~ack_s2_q;
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign bus_wr = bus_req & wb_we_in & wb_sel_in[0];
    assign bus_rd = bus_req & ~wb_we_in;
    assign adr_eff = dma_sel ? `OFS_DATA : wb_adr_in;

    assign fifo_empty_out = (count_q == 5'd0);
    assign fifo_full_out = (count_q == `FIFO_DEPTH);

    // Request bit paces host bytes; single byte on writes while FIFO is off
    assign host_transfer_request = ~any_reset & ~stop_q &
        (transfer_direction_in ? ~fifo_empty_out :
        (fifo_on_q ? ~fifo_full_out : fifo_empty_out)); // [RL1] [RL26]

    assign host_push = bus_wr & (adr_eff == `OFS_DATA) &
        ~transfer_direction_in & ~stop_q & ~fifo_full_out;
    assign host_pop = bus_rd & (adr_eff == `OFS_DATA) &
        transfer_direction_in & ~fifo_empty_out;
    assign push = host_push | (core_push_in & ~stop_q & ~fifo_full_out);
    assign pop = host_pop | (core_pop_in & ~stop_q & ~fifo_empty_out);
    assign overrun = in_exec_q & core_push_in & fifo_full_out;
    assign underrun = in_exec_q & core_pop_in & fifo_empty_out;

    // DMA request only while a transfer is running [RL24]
    assign dma_request_out = dma_en_q & in_exec_q &
        host_transfer_request & ~any_reset; // [RL3]

    // Disk-change bit inverted from cable, forced off in auto powerdown
    assign media_changed_flag = ~chg_s2_q & ~auto_pd_in; // [RL6] [RL7]
    assign high_density_indicator_n =
        ~((rate_q == `RATE_500K) | (rate_q == `RATE_1M)); // [RL11]
    // Basic mode takes the mask from the secondary status bit [RL16]
    assign idle_mask_eff = (mode_q == `MODE_BASIC) ? srb_mask_q :
        (idle_pin_mask_q & pd_stat_en_q);
    assign idle_pin_out = idle_in & ~idle_mask_eff; // [RL9]
    assign powerdown_state_flag_out = direct_pd_q | auto_pd_in;
    assign pd_bits = pd_stat_en_q ?
        {idle_in, powerdown_state_flag_out, idle_mask_eff} : 3'h0; // [RL8]
    assign rate_code_out = rate_q;
    assign skip_write_shift_out = skip_write_shift_q;

    // Data rate decode [RL25]
    always @* begin
        case (rate_q)
            `RATE_1M: data_rate_kbps_out = `KBPS_1M;
            `RATE_500K: data_rate_kbps_out = `KBPS_500K;
            `RATE_300K: data_rate_kbps_out = `KBPS_300K;
            default: data_rate_kbps_out = `KBPS_250K;
        endcase
    end

    // Input register view per mode [RL5]
    always @* begin
        case (mode_q)
            `MODE_EXT: begin
                dir_val = {media_changed_flag, pd_bits, 1'b1, rate_q,
                    high_density_indicator_n}; // [RL10]
            end
            `MODE_ALT: begin
                dir_val = {~media_changed_flag, pd_bits, dma_gate_n_q,
                    skip_write_shift_q, rate_q}; // [RL13] [RL14]
            end
            default: begin
                dir_val = {media_changed_flag, 7'h00};
            end
        endcase
    end

    // Read mux; write-only registers read as zero
    always @* begin
        case (adr_eff)
            `OFS_DOR: rd_val = {4'h0, dma_gate_n_q, 2'h0, dor_reset_q};
            `OFS_MSR: rd_val = {host_transfer_request,
                transfer_direction_in, in_exec_q & ~dma_en_q,
                ~any_reset & (in_exec_q | ~fifo_empty_out), 4'h0};
            `OFS_DATA: rd_val = mem_q[rd_ptr_q];
            `OFS_DIR: rd_val = dir_val;
            `OFS_CFG: rd_val = {3'h0, dma_en_q, srb_mask_q,
                pd_stat_en_q, mode_q};
            `OFS_STAT: rd_val = {term_flag_q, zero_fill_out, stop_q,
                count_q};
            default: rd_val = 8'h00;
        endcase
    end

    // Bus answer: one wait state, ack for one cycle
    always @(posedge clock_in) begin
        if (srst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= bus_req;
            if (bus_rd) begin
                wb_dat_out <= {24'h000000, rd_val};
            end
        end
    end

    // Software-written control state
    always @(posedge clock_in) begin
        if (srst_in) begin
            dor_reset_q <= 1'b1; // [RL20]
            dma_gate_n_q <= 1'b0;
            dsr_reset_q <= 1'b0;
            direct_pd_q <= 1'b0;
            rate_q <= `RATE_RESET; // [RL15]
            idle_pin_mask_q <= 1'b0;
            skip_write_shift_q <= 1'b0; // [RL17]
            mode_q <= `MODE_BASIC;
            pd_stat_en_q <= 1'b0;
            srb_mask_q <= 1'b0;
            dma_en_q <= 1'b0;
        end else begin
            dsr_reset_q <= 1'b0; // [RL22]
            if (sw_reset) begin
                direct_pd_q <= 1'b0; // [RL18]
            end
            if (spec_rate_we_in) begin
                rate_q <= spec_rate_in; // [RL12]
            end
            if (bus_wr) begin
                case (adr_eff)
                    `OFS_DOR: begin
                        dor_reset_q <= wb_dat_in[`DOR_RST_BIT]; // [RL23]
                        dma_gate_n_q <= wb_dat_in[`DOR_GATE_BIT];
                    end
                    `OFS_DSR: begin
                        dsr_reset_q <= wb_dat_in[`DSR_RST_BIT];
                        direct_pd_q <= wb_dat_in[`DSR_PD_BIT] &
                            ~wb_dat_in[`DSR_RST_BIT];
                        rate_q <= wb_dat_in[1:0];
                    end
                    `OFS_CCR: begin
                        rate_q <= wb_dat_in[1:0]; // [RL15]
                        if (pd_stat_en_q) begin
                            idle_pin_mask_q <=
                                wb_dat_in[`CCR_MASK_BIT]; // [RL16]
                        end
                        if (mode_q == `MODE_ALT) begin
                            skip_write_shift_q <=
                                wb_dat_in[`CCR_NOPRE_BIT]; // [RL17]
                        end
                    end
                    `OFS_CFG: begin
                        mode_q <= wb_dat_in[1:0];
                        pd_stat_en_q <= wb_dat_in[2];
                        srb_mask_q <= wb_dat_in[3];
                        dma_en_q <= wb_dat_in[4];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Command phase tracking, termination and zero fill
    always @(posedge clock_in) begin
        if (srst_in | sw_reset) begin
            fifo_on_q <= 1'b0; // [RL19]
            in_exec_q <= 1'b0;
            stop_q <= 1'b0;
            term_flag_q <= 1'b0;
            zero_fill_out <= 1'b0;
            terminate_out <= 1'b0;
        end else begin
            terminate_out <= 1'b0;
            if (cmd_start_in) begin
                fifo_on_q <= 1'b0; // [RL1]
                in_exec_q <= 1'b0;
                stop_q <= 1'b0;
                term_flag_q <= 1'b0;
            end else if (exec_start_in) begin
                fifo_on_q <= fifo_cfg_en_in;
                in_exec_q <= 1'b1;
            end else if (cmd_end_in) begin
                in_exec_q <= 1'b0;
                fifo_on_q <= 1'b0;
            end
            if ((overrun | underrun) & ~stop_q) begin
                stop_q <= 1'b1; // [RL3]
                term_flag_q <= 1'b1;
                terminate_out <= 1'b1;
                in_exec_q <= 1'b0;
                zero_fill_out <= underrun & is_disk_write_in; // [RL4]
            end else if (sector_done_in) begin
                zero_fill_out <= 1'b0;
            end
        end
    end

    // Byte to the core; zeros while padding the sector [RL4]
    always @(posedge clock_in) begin
        if (srst_in) begin
            core_data_out <= 8'h00;
        end else if (zero_fill_out | (stop_q & core_pop_in)) begin
            core_data_out <= 8'h00;
        end else if (core_pop_in & ~fifo_empty_out) begin
            core_data_out <= mem_q[rd_ptr_q];
        end
    end

    // FIFO pointers; flushed when execution begins [RL2]
    always @(posedge clock_in) begin
        if (fifo_reset | exec_start_in) begin
            wr_ptr_q <= 4'h0; // [RL21]
            rd_ptr_q <= 4'h0;
            count_q <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 4'h1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 5'h01;
            end else if (pop & ~push) begin
                count_q <= count_q - 5'h01;
            end
        end
    end

    always @(posedge clock_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= host_push ? wb_dat_in[7:0] : core_data_in;
        end
    end

    // Polling starts when reset is released [RL19]
    always @(posedge clock_in) begin
        if (srst_in) begin
            was_reset_q <= 1'b1;
            poll_enable_out <= 1'b0;
        end else begin
            was_reset_q <= any_reset;
            if (any_reset) begin
                poll_enable_out <= 1'b0;
            end else if (was_reset_q) begin
                poll_enable_out <= 1'b1;
            end else if (poll_disable_in) begin
                poll_enable_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/fdc_host_props_properties.sv ====
// Concurrent checks on the floppy host port
`timescale 1ns/10ps
`default_nettype none
`include "fdc_host_consts.vh"
module fdc_host_props (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic idle_in,
    input wire logic idle_pin_out,
    input wire logic auto_pd_in,
    input wire logic core_push_in,
    input wire logic core_pop_in,
    input wire logic exec_start_in,
    input wire logic is_disk_write_in,
    input wire logic sector_done_in,
    input wire logic spec_rate_we_in,
    input wire logic [1:0] spec_rate_in,
    input wire logic fifo_empty_out,
    input wire logic terminate_out,
    input wire logic zero_fill_out,
    input wire logic core_reset_out,
    input wire logic powerdown_state_flag_out,
    input wire logic [1:0] rate_code_out,
    input wire logic [10:0] data_rate_kbps_out,
    input wire logic skip_write_shift_out
);
default clocking cb @(posedge clock_in); endclocking
default disable iff (srst_in);
sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
endsequence
sequence s_ack;
    wb_ack_out ##1 !wb_ack_out;
endsequence
a_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus request without one ack pulse");
a_rate_decode: assert property (data_rate_kbps_out ==
    (rate_code_out == `RATE_1M ? `KBPS_1M :
    rate_code_out == `RATE_500K ? `KBPS_500K :
    rate_code_out == `RATE_300K ? `KBPS_300K : `KBPS_250K))
    else $error("rate decode wrong");
a_hw_reset: assert property ($fell(srst_in) |-> core_reset_out &&
    rate_code_out == `RATE_RESET && !skip_write_shift_out)
    else $error("state after pin reset wrong");
a_pd_exit: assert property ($fell(srst_in) && !auto_pd_in |->
    !powerdown_state_flag_out) else $error("powerdown kept over reset");
a_idle_mask: assert property (idle_pin_out |-> idle_in)
    else $error("idle pin without idle");
a_term_pulse: assert property (terminate_out |->
    $past(core_push_in || core_pop_in) ##1 !terminate_out)
    else $error("terminate without cause or too long");
a_flush_exec: assert property (exec_start_in && !core_push_in |=>
    fifo_empty_out) else $error("fifo not flushed at execution");
a_zero_rise: assert property ($rose(zero_fill_out) |->
    $past(is_disk_write_in)) else $error("zero fill on a read");
a_zero_clear: assert property (zero_fill_out && sector_done_in |=>
    !zero_fill_out) else $error("zero fill past sector end");
a_spec_rate: assert property (spec_rate_we_in &&
    !(wb_cyc_in && wb_stb_in) |=> rate_code_out == $past(spec_rate_in))
    else $error("rate not loaded by drive command");
a_soft_release: assert property ($fell(core_reset_out) |->
    wb_ack_out || $past(wb_ack_out)) else $error("reset left by itself");
endmodule
bind fdc_host_status_reset_logic fdc_host_props chk_u (.clock_in, .srst_in,
    .wb_cyc_in, .wb_stb_in, .wb_ack_out, .idle_in, .idle_pin_out,
    .auto_pd_in, .core_push_in, .core_pop_in, .exec_start_in,
    .is_disk_write_in, .sector_done_in, .spec_rate_we_in, .spec_rate_in,
    .fifo_empty_out, .terminate_out, .zero_fill_out, .core_reset_out,
    .powerdown_state_flag_out, .rate_code_out, .data_rate_kbps_out,
    .skip_write_shift_out);
`default_nettype wire

// ==== bench/host_dma_model.sv ====
// Model of the system DMA controller answering transfer requests
`timescale 1ns/10ps
`default_nettype none
module host_dma_model (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic dma_request_in,
    input wire logic [3:0] delay_in,
    output logic dma_acknowledge_n_out = 1'b1
);
logic [3:0] wait_q = 4'h0;
always @(posedge clock_in) begin
    if (srst_in || !dma_request_in) begin
        wait_q <= 4'h0;
        dma_acknowledge_n_out <= 1'b1; // Release once request drops
    end else if (wait_q == delay_in) begin
        dma_acknowledge_n_out <= 1'b0; // Select the data port
    end else begin
        wait_q <= wait_q + 4'h1;
    end
end
endmodule
`default_nettype wire

// ==== bench/fdc_host_status_reset_logic_test.sv ====
// Self-checking bench for the floppy host status and reset logic
`timescale 1ns/10ps
`default_nettype none
`include "fdc_host_consts.vh"
`define CMP(a, e) begin \
    total_checks++; \
    if ((a) !== (e)) begin \
        mismatches++; \
        $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    end \
end
module fdc_host_status_reset_logic_test;
logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, chg = 0, idle = 0;
logic apd = 0, dir = 0, lock = 0, wr = 0, fen = 0, pdis = 0;
logic [7:0] adr = 0, cdat = 0, q, msk;
logic [31:0] wdat = 0, v;
logic [3:0] sel = 4'hF, dly = 0;
logic [5:0] ev = 0;
logic [1:0] srate = 0, m;
logic [10:0] kt [4] = '{`KBPS_500K, `KBPS_300K, `KBPS_250K, `KBPS_1M};
wire ack, dma_request, ipin, emp, full, crst, term, zf, poll, pd, skip, dma_acknowledge_n_n;
wire [31:0] rdat;
wire [1:0] rate;
wire [7:0] cq;
wire [10:0] kbps;
int mismatches = 0, total_checks = 0, cycles = 0, terms = 0, t0, n;
int seed = 32'h02c0a740;
fdc_host_status_reset_logic dut_u (.clock_in(clk), .srst_in(srst),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .media_change_pin_in(chg), .dma_acknowledge_n_in(dma_acknowledge_n_n),
    .dma_request_out(dma_request), .idle_pin_out(ipin), .idle_in(idle),
    .auto_pd_in(apd), .cmd_start_in(ev[2]), .exec_start_in(ev[3]),
    .cmd_end_in(1'b0), .transfer_direction_in(dir), .lock_in(lock),
    .fifo_cfg_en_in(fen), .poll_disable_in(pdis),
    .spec_rate_we_in(ev[5]), .spec_rate_in(srate), .core_pop_in(ev[1]),
    .core_data_out(cq), .core_push_in(ev[0]), .core_data_in(cdat),
    .sector_done_in(ev[4]), .is_disk_write_in(wr), .fifo_empty_out(emp),
    .fifo_full_out(full), .core_reset_out(crst), .terminate_out(term),
    .zero_fill_out(zf), .poll_enable_out(poll),
    .powerdown_state_flag_out(pd), .rate_code_out(rate),
    .data_rate_kbps_out(kbps), .skip_write_shift_out(skip));
host_dma_model dma_u (.clock_in(clk), .srst_in(srst),
    .dma_request_in(dma_request), .delay_in(dly), .dma_acknowledge_n_out(dma_acknowledge_n_n));
initial forever #2.5 clk = ~clk;
always @(posedge clk) begin
    cycles++;
    if (term === 1'b1)
        terms++;
    if (cycles == 30000) begin
        mismatches++;
        tally_and_finish();
    end
end
task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task tick(input int k);
    repeat (k) @(posedge clk);
endtask
task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int c;
    c = 0;
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && c < 40) begin
        c++;
        @(posedge clk);
    end
    q = rdat[7:0];
    if (c == 40)
        mismatches++;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
endtask
task pulse(input logic [5:0] e);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
    @(posedge clk);
endtask
function automatic logic [7:0] dir_exp(input logic [1:0] md,
    input logic c, input logic [1:0] r, input logic i, input logic k,
    input logic g, input logic np, input logic ap);
    logic hd;
    hd = !(r == `RATE_500K || r == `RATE_1M);
    case (md)
        `MODE_BASIC: return {~c & ~ap, 7'h00};
        `MODE_EXT: return {~c & ~ap, i, 1'b0, k, 1'b1, r, hd};
        default: return {c | ap, i, 1'b0, k, g, np, r};
    endcase
endfunction
initial begin
    tick(4);
    srst <= 1'b0;
    tick(1);
    `CMP(crst, 1'b1);
    `CMP(rate, `RATE_RESET);
    tick(100);
    wb(1, `OFS_DOR, 8'h00);
    tick(3);
    `CMP(poll, 1'b1);
    pdis <= 1'b1;
    tick(2);
    `CMP(poll, 1'b0);
    pdis <= 1'b0;
    for (int i = 0; i < 45; i++) begin
        v = $random(seed);
        m = i % 3;
        chg <= v[6];
        idle <= v[7];
        apd <= v[8] & v[9];
        wb(1, `OFS_DOR, {4'h0, v[3], 3'h0});
        wb(1, `OFS_CFG, {4'h0, v[5], 1'b1, m});
        wb(1, `OFS_CCR, {3'h0, v[2], 1'b0, v[4], v[1:0]});
        wb(1, `OFS_DIR, v[23:16]);
        wb(0, `OFS_DIR, 8'h00);
        msk = apd ? 8'h9F : 8'hFF;
        `CMP(q & msk, dir_exp(m, v[6], v[1:0], v[7], v[2], v[3], v[4], apd) & msk);
        `CMP(ipin, idle & ~(m == `MODE_BASIC ? v[5] : v[2]));
        wb(0, `OFS_CCR, 8'h00);
        `CMP(q, 8'h00);
    end
    apd <= 1'b0;
    wb(0, 8'hFC, 8'h00);
    `CMP(q, 8'h00);
    for (int j = 0; j < 4; j++) begin
        srate <= j;
        pulse(6'h20);
        `CMP(rate, j[1:0]);
        `CMP(kbps, kt[j]);
    end
    wb(1, `OFS_CCR, 8'h05);
    wb(1, `OFS_DSR, 8'h41);
    `CMP(pd, 1'b1);
    wb(1, `OFS_DSR, 8'h81);
    tick(2);
    `CMP(pd, 1'b0);
    `CMP(crst, 1'b0);
    `CMP(skip, 1'b1);
    `CMP(rate, 2'h1);
    lock <= 1'b1;
    pulse(6'h01);
    wb(1, `OFS_DSR, 8'h81);
    `CMP(emp, 1'b0);
    lock <= 1'b0;
    wb(1, `OFS_DSR, 8'h81);
    `CMP(emp, 1'b1);
    wb(1, `OFS_DOR, 8'h01);
    tick(100);
    `CMP(crst, 1'b1);
    wb(0, `OFS_MSR, 8'h00);
    `CMP(q, 8'h00);
    wb(1, `OFS_DOR, 8'h00);
    pulse(6'h04);
    repeat (3) pulse(6'h01);
    fen <= 1'b1;
    pulse(6'h08);
    `CMP(emp, 1'b1);
    cdat <= 8'hA5;
    repeat (3) pulse(6'h01);
    wb(0, `OFS_MSR, 8'h00);
    `CMP(q, 8'hB0);
    repeat (13) pulse(6'h01);
    `CMP(full, 1'b1);
    t0 = terms;
    pulse(6'h01);
    tick(2);
    `CMP(terms, t0 + 1);
    wr <= 1'b1;
    pulse(6'h04);
    pulse(6'h02);
    `CMP(cq, 8'hA5);
    wb(0, `OFS_MSR, 8'h00);
    `CMP(q, 8'h10);
    pulse(6'h08);
    t0 = terms;
    pulse(6'h02);
    tick(2);
    `CMP(terms, t0 + 1);
    `CMP(zf, 1'b1);
    pulse(6'h02);
    `CMP(cq, 8'h00);
    pulse(6'h10);
    `CMP(zf, 1'b0);
    wr <= 1'b0;
    for (int j = 0; j < 2; j++) begin
        dly <= j * 9;
        dir <= 1'b1;
        wb(1, `OFS_CFG, 8'h10);
        pulse(6'h04);
        pulse(6'h08);
        cdat <= $random(seed);
        pulse(6'h01);
        n = 0;
        while (dma_acknowledge_n_n !== 1'b0 && n < 50) begin
            n++;
            tick(1);
        end
        tick(3);
        wb(0, `OFS_DIR, 8'h00);
        `CMP(q, cdat);
        dir <= 1'b0;
        tick(6);
    end
    srst <= 1'b1;
    tick(1);
    srst <= 1'b0;
    tick(1);
    `CMP(crst, 1'b1);
    `CMP(skip, 1'b0);
    `CMP(rate, `RATE_RESET);
    tally_and_finish();
end
endmodule
`default_nettype wire
